// *** src/ctm_pkg.sv ***
// Constants for the compact 10-bit timer with compare and PWM output
package ctm_pkg;

  // ----------------------------------------------------------------
  // Counter geometry
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W    = 10;
  localparam int unsigned RP_W     = 3;
  localparam int unsigned RP_LSB   = 7;
  localparam int unsigned SPAN_W   = 11;
  localparam logic [10:0] FULL_SPAN = 11'h400;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CMPA  = 8'h0C;
  localparam logic [7:0] OFS_FLAGS = 8'h10;

  // ----------------------------------------------------------------
  // Control 0 fields
  // ----------------------------------------------------------------
  localparam int unsigned C0_ENABLE  = 3;
  localparam int unsigned C0_RP_LSB  = 0;

  // ----------------------------------------------------------------
  // Control 1 fields
  // ----------------------------------------------------------------
  localparam int unsigned C1_MODE_HI = 7;
  localparam int unsigned C1_MODE_LO = 6;
  localparam int unsigned C1_ACT_HI  = 5;
  localparam int unsigned C1_ACT_LO  = 4;
  localparam int unsigned C1_INIT    = 3;
  localparam int unsigned C1_INVERT  = 2;
  localparam int unsigned C1_SWAP    = 1;
  localparam int unsigned C1_CLRSEL  = 0;

  // ----------------------------------------------------------------
  // Flag fields
  // ----------------------------------------------------------------
  localparam int unsigned FL_A = 0;
  localparam int unsigned FL_P = 1;

  // ----------------------------------------------------------------
  // Modes and output actions
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_CMP  = 2'h0;
  localparam logic [1:0] MODE_UNDF = 2'h1;
  localparam logic [1:0] MODE_PWM  = 2'h2;
  localparam logic [1:0] MODE_TC   = 2'h3;
  localparam logic [1:0] ACT_NONE  = 2'h0;
  localparam logic [1:0] ACT_LOW   = 2'h1;
  localparam logic [1:0] ACT_HIGH  = 2'h2;
  localparam logic [1:0] ACT_TOG   = 2'h3;

  // ----------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [9:0] CMPA_RST  = 10'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned TICK_DIV_DEF = 1;

endpackage

// *** src/compact_timer_module.sv ***
// Compact 10-bit timer: counter, two comparators, compare/PWM output, AXI4-Lite registers
//
// Operation
// - Initial level sets start or active level
// - Invert bit inverts pin outside timer mode
// - Swap bit exchanges period and duty sources
// - Clear select picks comparator A or P
// - Overflow clear only with period bits zero
// - PWM ignores clear select, swap picks
// - Mode field: 00 compare, 11 timer, 10 PWM
// - Compare mode clear-P raises both flags
// - Clear select A raises no P flag outside PWM
// - Compare A zero wraps at 3FF, no flag
// - Compare mode pin changes only on comparator A match or enable rise
// - Action field: none, low, high, toggle
// - Enable rising edge loads initial pin level
// - Timer mode counts alike, pin released
// - PWM: one compare clears, other sets duty
// - PWM raises both flags on matches
// - PWM counting continues with forced pin levels
// - Period codes give 128 steps, 000 gives 1024
// - Duty at or above period: always active
// - Swapped: compare A period, code gives duty
// - Enable rise clears counter, fall holds it
// - Period code compared with counter bits 9..7
// - PWM action: inactive, active, waveform, undefined
`timescale 1ns/1ps

module compact_timer_module #(
  parameter int unsigned TICK_DIV = ctm_pkg::TICK_DIV_DEF,
  parameter int unsigned ADDR_W   = 8
) (
  input  wire logic              mclk_in,
  input  wire logic              reset_in,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  input  wire logic              timer_output_pin_0_in,
  output logic                   timer_output_pin_0_out,
  output logic                   timer_output_pin_0_oe_n_out,
  input  wire logic              timer_output_pin_1_in,
  output logic                   timer_output_pin_1_out,
  output logic                   timer_output_pin_1_oe_n_out,
  output logic                   compare_a_match_flag_out,
  output logic                   compare_p_match_flag_out
);

  initial begin
    if (TICK_DIV < 1 || TICK_DIV > 65536) begin
      $error("TICK_DIV must lie between 1 and 65536");
    end
    if (ADDR_W < 8 || ADDR_W > 32) begin
      $error("ADDR_W must lie between 8 and 32");
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [10:0] rp_span(input logic [2:0] code);
    rp_span = (code == 3'h0) ? ctm_pkg::FULL_SPAN : {1'b0, code, 7'h00};
  endfunction

  function automatic logic [10:0] a_span(input logic [9:0] value);
    a_span = (value == 10'h000) ? ctm_pkg::FULL_SPAN : {1'b0, value};
  endfunction

  function automatic logic [7:0] word_ofs(input logic [ADDR_W-1:0] addr);
    word_ofs = {addr[7:2], 2'h0};
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0]        ctrl0_reg;
  logic [7:0]        ctrl1_reg;
  logic [9:0]        cmpa_reg;
  logic [9:0]        cnt_reg;
  logic              flag_a_reg;
  logic              flag_p_reg;
  logic              en_d_reg;
  logic              cmp_level_reg;
  logic              pin_reg;
  logic              pin_oe_n_reg;
  logic [15:0]       div_reg;
  logic              tick_reg;

  logic              en;
  logic [2:0]        rp;
  logic [1:0]        mode;
  logic [1:0]        action;
  logic              init_lvl;
  logic              invert;
  logic              swap;
  logic              clr_sel;

  assign en       = ctrl0_reg[ctm_pkg::C0_ENABLE];
  assign rp       = ctrl0_reg[ctm_pkg::C0_RP_LSB +: ctm_pkg::RP_W];
  assign mode     = ctrl1_reg[ctm_pkg::C1_MODE_HI:ctm_pkg::C1_MODE_LO];
  assign action   = ctrl1_reg[ctm_pkg::C1_ACT_HI:ctm_pkg::C1_ACT_LO];
  assign init_lvl = ctrl1_reg[ctm_pkg::C1_INIT];
  assign invert   = ctrl1_reg[ctm_pkg::C1_INVERT];
  assign swap     = ctrl1_reg[ctm_pkg::C1_SWAP];
  assign clr_sel  = ctrl1_reg[ctm_pkg::C1_CLRSEL];

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] aw_addr_reg;
  logic              aw_have_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              w_have_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              wr_fire;
  logic [7:0]        wr_ofs;
  logic              wr_known;

  assign s_axi_awready_out = !aw_have_reg && !bvalid_reg;
  assign s_axi_wready_out  = !w_have_reg && !bvalid_reg;
  assign s_axi_bvalid_out  = bvalid_reg;
  assign s_axi_bresp_out   = bresp_reg;
  assign wr_fire           = aw_have_reg && w_have_reg && !bvalid_reg;
  assign wr_ofs            = word_ofs(aw_addr_reg);
  assign wr_known          = (wr_ofs <= ctm_pkg::OFS_FLAGS);

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_have_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr_in;
    end else if (wr_fire) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      w_have_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_have_reg <= 1'b1;
      w_data_reg <= s_axi_wdata_in;
      w_strb_reg <= s_axi_wstrb_in;
    end else if (wr_fire) begin
      w_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= ctm_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_known ? ctm_pkg::RESP_OKAY : ctm_pkg::RESP_SLVERR;
    end else if (s_axi_bready_in) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ctrl0_reg <= ctm_pkg::CTRL0_RST;
      ctrl1_reg <= ctm_pkg::CTRL1_RST;
      cmpa_reg  <= ctm_pkg::CMPA_RST;
    end else if (wr_fire) begin
      if (wr_ofs == ctm_pkg::OFS_CTRL0 && w_strb_reg[0]) begin
        ctrl0_reg <= w_data_reg[7:0];
      end
      if (wr_ofs == ctm_pkg::OFS_CTRL1 && w_strb_reg[0]) begin
        ctrl1_reg <= w_data_reg[7:0];
      end
      if (wr_ofs == ctm_pkg::OFS_CMPA && w_strb_reg[0]) begin
        cmpa_reg[7:0] <= w_data_reg[7:0];
      end
      if (wr_ofs == ctm_pkg::OFS_CMPA && w_strb_reg[1]) begin
        cmpa_reg[9:8] <= w_data_reg[9:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic [7:0]        rd_ofs;

  assign s_axi_arready_out = !rvalid_reg;
  assign s_axi_rvalid_out  = rvalid_reg;
  assign s_axi_rdata_out   = rdata_reg;
  assign s_axi_rresp_out   = rresp_reg;
  assign rd_ofs            = word_ofs(s_axi_araddr_in);

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= ctm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= ctm_pkg::RESP_OKAY;
      case (rd_ofs)
        ctm_pkg::OFS_CTRL0: rdata_reg <= {24'h000000, ctrl0_reg};
        ctm_pkg::OFS_CTRL1: rdata_reg <= {24'h000000, ctrl1_reg};
        ctm_pkg::OFS_COUNT: rdata_reg <= {22'h000000, cnt_reg};
        ctm_pkg::OFS_CMPA:  rdata_reg <= {22'h000000, cmpa_reg};
        ctm_pkg::OFS_FLAGS: rdata_reg <= {30'h00000000, flag_p_reg, flag_a_reg};
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= ctm_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready_in) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Timer clock enable
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      div_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (div_reg >= 16'(TICK_DIV - 1)) begin
      div_reg  <= 16'h0000;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Counter and comparators
  // ----------------------------------------------------------------
  logic        en_rise;
  logic        run;
  logic [9:0]  inc;
  logic        a_match;
  logic        p_match;
  logic        clr_by_a;
  logic        a_set;
  logic        p_set;

  assign en_rise = en && !en_d_reg;
  assign run     = en && tick_reg && (mode != ctm_pkg::MODE_UNDF);
  assign inc     = cnt_reg + 10'h001;
  // Zero compare A never matches so the counter wraps at 3FF
  assign a_match = (inc == cmpa_reg) && (cmpa_reg != 10'h000);
  // Only the top three bits meet the period code; code 000 is the wrap
  assign p_match = (inc[9:7] == rp) && (inc[6:0] == 7'h00);
  assign clr_by_a = (mode == ctm_pkg::MODE_PWM) ? swap : clr_sel;
  assign a_set   = run && !en_rise && a_match;
  assign p_set   = run && !en_rise && p_match
                   && ((mode == ctm_pkg::MODE_PWM) || !clr_sel);

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      en_d_reg <= 1'b0;
    end else begin
      en_d_reg <= en;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cnt_reg <= 10'h000;
    end else if (en_rise) begin
      cnt_reg <= 10'h000;
    end else if (run) begin
      if (clr_by_a ? a_match : p_match) begin
        cnt_reg <= 10'h000;
      end else begin
        cnt_reg <= inc;
      end
    end
  end

  // ----------------------------------------------------------------
  // Match flags, write one to clear, a new match wins over the clear
  // ----------------------------------------------------------------
  logic flag_clr_a;
  logic flag_clr_p;

  assign flag_clr_a = wr_fire && (wr_ofs == ctm_pkg::OFS_FLAGS) && w_strb_reg[0]
                      && w_data_reg[ctm_pkg::FL_A];
  assign flag_clr_p = wr_fire && (wr_ofs == ctm_pkg::OFS_FLAGS) && w_strb_reg[0]
                      && w_data_reg[ctm_pkg::FL_P];

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      flag_a_reg <= 1'b0;
      flag_p_reg <= 1'b0;
    end else begin
      if (a_set) begin
        flag_a_reg <= 1'b1;
      end else if (flag_clr_a) begin
        flag_a_reg <= 1'b0;
      end
      if (p_set) begin
        flag_p_reg <= 1'b1;
      end else if (flag_clr_p) begin
        flag_p_reg <= 1'b0;
      end
    end
  end

  assign compare_a_match_flag_out = flag_a_reg;
  assign compare_p_match_flag_out = flag_p_reg;

  // ----------------------------------------------------------------
  // Compare-match output level
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      cmp_level_reg <= 1'b0;
    end else if (en_rise) begin
      cmp_level_reg <= init_lvl;
    end else if (a_set && mode == ctm_pkg::MODE_CMP) begin
      case (action)
        ctm_pkg::ACT_LOW:  cmp_level_reg <= 1'b0;
        ctm_pkg::ACT_HIGH: cmp_level_reg <= 1'b1;
        ctm_pkg::ACT_TOG:  cmp_level_reg <= !cmp_level_reg;
        default:           cmp_level_reg <= cmp_level_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // PWM waveform and pin driver
  // ----------------------------------------------------------------
  logic [10:0] duty;
  logic        pwm_on;
  logic        pwm_level;
  logic        pin_level;

  assign duty   = swap ? rp_span(rp) : a_span(cmpa_reg);
  // Active from each clear until the duty count; duty at or past period stays on
  assign pwm_on = ({1'b0, cnt_reg} < duty);

  always_comb begin
    case (action)
      ctm_pkg::ACT_NONE: pwm_level = !init_lvl;
      ctm_pkg::ACT_LOW:  pwm_level = init_lvl;
      ctm_pkg::ACT_HIGH: pwm_level = pwm_on ? init_lvl : !init_lvl;
      default:           pwm_level = !init_lvl;
    endcase
  end

  assign pin_level = ((mode == ctm_pkg::MODE_PWM) ? pwm_level : cmp_level_reg)
                     ^ invert;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pin_reg      <= 1'b0;
      pin_oe_n_reg <= 1'b1;
    end else begin
      pin_reg      <= pin_level;
      pin_oe_n_reg <= (mode == ctm_pkg::MODE_TC) || (mode == ctm_pkg::MODE_UNDF);
    end
  end

  assign timer_output_pin_0_out      = pin_reg;
  assign timer_output_pin_1_out      = pin_reg;
  assign timer_output_pin_0_oe_n_out = pin_oe_n_reg;
  assign timer_output_pin_1_oe_n_out = pin_oe_n_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  chk_enable_rise_clear: assert property (
    en_rise |=> (cnt_reg == 10'h000))
    else $error("counter not cleared on enable rise");

  chk_disable_hold_count: assert property (
    (!en && !en_d_reg) |=> $stable(cnt_reg))
    else $error("counter moved while disabled");

  chk_period_clear: assert property (
    (run && !en_rise && !clr_by_a && p_match) |=> (cnt_reg == 10'h000) && flag_p_reg)
    else $error("period match did not clear counter");

  chk_no_p_flag: assert property (
    (mode == ctm_pkg::MODE_CMP && clr_sel && !flag_p_reg) |=> !flag_p_reg)
    else $error("period flag raised with clear on A");

  chk_a_zero_wrap: assert property (
    (run && !en_rise && cnt_reg == 10'h3FF && cmpa_reg == 10'h000 && !flag_a_reg
     && !$past(a_set)) |=> (cnt_reg == 10'h000) && !flag_a_reg)
    else $error("zero compare A raised flag or failed to wrap");

  chk_timer_pin_free: assert property (
    (mode == ctm_pkg::MODE_TC) |=> timer_output_pin_0_oe_n_out)
    else $error("pin driven in timer mode");

  chk_cmp_action_high: assert property (
    (a_set && !en_rise && mode == ctm_pkg::MODE_CMP && action == ctm_pkg::ACT_HIGH)
    |=> cmp_level_reg ##1 (timer_output_pin_0_out == !$past(invert)))
    else $error("compare high action not seen on pin");

  chk_rise_init_level: assert property (
    en_rise |=> (cmp_level_reg == $past(init_lvl)))
    else $error("initial level not loaded on enable rise");

  chk_full_duty: assert property (
    (mode == ctm_pkg::MODE_PWM && action == ctm_pkg::ACT_HIGH && !swap && en
     && a_span(cmpa_reg) >= rp_span(rp) && {1'b0, cnt_reg} < rp_span(rp)
     && $stable(ctrl1_reg)) |=> (timer_output_pin_0_out == ($past(init_lvl) ^ $past(invert))))
    else $error("full duty PWM not held active");

  chk_flag_set_wins: assert property (
    a_set |=> flag_a_reg)
    else $error("compare A match lost");

endmodule // compact_timer_module

// *** tb/pin_load_model.sv ***
// Load hung on one timer output pin: pull-up resistor with level feedback
`timescale 1ns/1ps

module pin_load_model (
  input  wire logic pin_drive_in,
  input  wire logic pin_oe_n_in,
  output logic      pin_level_out
);
  // ----
  // Wire level
  // ----
  // A released pin is pulled up, never left at the last driven value
  assign pin_level_out = pin_oe_n_in ? 1'b1 : pin_drive_in;
endmodule // pin_load_model

// *** tb/compact_timer_pwm_10bit_tb_top.sv ***
// Self-checking testbench for the compact timer over its register bus
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module compact_timer_pwm_10bit_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awready, wready, bvalid, arready, rvalid, p0, p1, oe0, oe1, fa, fp, l0, l1;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rd, held;
  int          err_count = 0;
  int          checked = 0;
  int          n;

  always #12.5 clk = ~clk;

  compact_timer_module #(.TICK_DIV(1), .ADDR_W(8)) i_dut (
    .mclk_in(clk), .reset_in(rst),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .timer_output_pin_0_in(l0), .timer_output_pin_0_out(p0), .timer_output_pin_0_oe_n_out(oe0),
    .timer_output_pin_1_in(l1), .timer_output_pin_1_out(p1), .timer_output_pin_1_oe_n_out(oe1),
    .compare_a_match_flag_out(fa), .compare_p_match_flag_out(fp)
  );

  pin_load_model i_load0 (.pin_drive_in(p0), .pin_oe_n_in(oe0), .pin_level_out(l0));
  pin_load_model i_load1 (.pin_drive_in(p1), .pin_oe_n_in(oe1), .pin_level_out(l1));

  // ----
  // Bus and helper tasks
  // ----
  task automatic finish_test;
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hF; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic wait_a;
    n = 0;
    while (fa !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    `CHK("a flag seen", 1'b1, fa);
  endtask

  // Configure while stopped, clear flags, then start the counter
  task automatic setup(input logic [7:0] c, input logic [9:0] a, input logic [2:0] code);
    wr(ctm_pkg::OFS_CTRL0, {29'h0, code});
    wr(ctm_pkg::OFS_CMPA, {22'h0, a});
    wr(ctm_pkg::OFS_CTRL1, {24'h0, c});
    wr(ctm_pkg::OFS_FLAGS, 32'h3);
    wr(ctm_pkg::OFS_CTRL0, {28'h0, 1'b1, code});
    cyc(3);
  endtask

  // Count high pin cycles over exactly one period after settling
  task automatic pwm_case(input logic [7:0] c, input logic [9:0] a, input logic [2:0] code,
                          input int win, input int exp_high);
    setup(c, a, code);
    cyc(2 * win);
    n = 0;
    repeat (win) begin
      @(posedge clk);
      if (p0 === 1'b1) n++;
    end
    `CHK("pwm high count", exp_high, n);
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    cyc(3);
    rst <= 1'b0;
    rd_reg(ctm_pkg::OFS_CTRL1);
    `CHK("ctrl1 reset", 32'h0, rd);
    rd_reg(8'h14);
    `CHK("unmapped read", ctm_pkg::RESP_SLVERR, rs);
    wr(8'h14, 32'h1);
    `CHK("unmapped write", ctm_pkg::RESP_SLVERR, rs);
    wr(ctm_pkg::OFS_CTRL1, 32'hA5);
    rd_reg(ctm_pkg::OFS_CTRL1);
    `CHK("ctrl1 readback", 32'hA5, rd);
    setup(8'h39, 10'd200, 3'd1);
    `CHK("pin init level", 1'b1, p0);
    wait_a;
    cyc(2);
    `CHK("pin after toggle", 1'b0, p0);
    `CHK("p flag clear sel a", 1'b0, fp);
    wr(ctm_pkg::OFS_CTRL0, 32'h1);
    rd_reg(ctm_pkg::OFS_COUNT);
    held = rd;
    cyc(5);
    rd_reg(ctm_pkg::OFS_COUNT);
    `CHK("count held", held, rd);
    wr(ctm_pkg::OFS_CTRL0, 32'h9);
    cyc(3);
    `CHK("pin reload", 1'b1, p0);
    `CHK("pin 1 reload", 1'b1, p1);
    rd_reg(ctm_pkg::OFS_COUNT);
    `CHK("count restarted", 1'b1, rd < 32'd40);
    for (int k = 0; k < 4; k++) begin
      setup({2'b00, 2'(k), 4'h8}, 10'd100, 3'd1);
      wait_a;
      cyc(2);
      `CHK("pin action", logic'(k == 0 || k == 2), p0);
    end
    cyc(40);
    `CHK("p flag clear sel p", 1'b1, fp);
    rd_reg(ctm_pkg::OFS_COUNT);
    `CHK("count cleared at 128", 1'b1, rd < 32'd128);
    setup(8'h01, 10'd0, 3'd0);
    cyc(1100);
    `CHK("a flag with zero compare", 1'b0, fa);
    `CHK("p flag with zero compare", 1'b0, fp);
    setup(8'hC0, 10'd100, 3'd1);
    cyc(140);
    `CHK("pin released", 1'b1, oe1);
    `CHK("pin pulled up", 1'b1, l0);
    `CHK("timer a flag", 1'b1, fa);
    `CHK("timer p flag", 1'b1, fp);
    setup(8'h40, 10'd100, 3'd1);
    rd_reg(ctm_pkg::OFS_COUNT);
    `CHK("undefined mode stopped", 32'h0, rd);
    `CHK("undefined mode released", 1'b1, oe0);
    pwm_case(8'hA8, 10'd32, 3'd1, 128, 32);
    `CHK("pwm a flag", 1'b1, fa);
    `CHK("pwm p flag", 1'b1, fp);
    pwm_case(8'hAC, 10'd32, 3'd1, 128, 96);
    pwm_case(8'hA9, 10'd32, 3'd1, 128, 32);
    pwm_case(8'hA8, 10'd200, 3'd1, 128, 128);
    pwm_case(8'hAA, 10'd300, 3'd2, 300, 256);
    pwm_case(8'h88, 10'd32, 3'd1, 128, 0);
    pwm_case(8'h98, 10'd32, 3'd1, 128, 128);
    `CHK("forced pwm a flag", 1'b1, fa);
    pwm_case(8'hB8, 10'd32, 3'd1, 128, 0);
    pwm_case(8'hA0, 10'd32, 3'd1, 128, 96);
    finish_test;
  end

  // Whole run needs about 6500 cycles; allow some 80000
  initial begin
    #2_000_000;
    err_count++;
    finish_test;
  end
endmodule // compact_timer_pwm_10bit_tb_top
